/* File: inc/rsoc_cfg.svh */
/*
 Addresses, field positions, reset values and timing counts of the reset
 source and option block. Assumes byte addressing on a 16-bit register port.
*/
`ifndef RSOC_CFG_SVH
`define RSOC_CFG_SVH

// Register addresses
`define RSOC_ADDR_PM0        16'h0004
`define RSOC_ADDR_WRITE_PROTECT_REGISTER       16'h000a
`define RSOC_ADDR_RESET_CAUSE_FLAGS      16'h000b
`define RSOC_ADDR_MONITOR_CONTROL_REGISTER       16'h0032
`define RSOC_ADDR_WATCHDOG_OPTION_BYTE       16'hffdb
`define RSOC_ADDR_OFS        16'hffff

// Field positions
`define RSOC_PM0_SOFT_BIT    3
`define RSOC_WRITE_PROTECT_REGISTER_UNLOCK_BIT 1
`define RSOC_MONITOR_CONTROL_REGISTER_EN_BIT     0
`define RSOC_RF_CWR_BIT      0
`define RSOC_RF_HWR_BIT      1
`define RSOC_RF_SWR_BIT      2
`define RSOC_RF_WDR_BIT      3
`define RSOC_OFS_WATCHDOG_AUTOSTART_SELECT_BIT   0
`define RSOC_OFS_ROM_PROTECT_GATE_BIT   2
`define RSOC_OFS_ROMCP_BIT   3
`define RSOC_OFS_VDSEL_LO    4
`define RSOC_OFS_MONITOR_START_SELECT_BIT   6
`define RSOC_OFS_CSPRO_BIT   7
`define RSOC_WATCHDOG_OPTION_BYTE_UFS_LO     0
`define RSOC_WATCHDOG_OPTION_BYTE_RCS_LO     2

// Reset and erased values
`define RSOC_ERASED_BYTE     8'hff
`define RSOC_PM0_RESET       8'h00
`define RSOC_ZERO_BYTE       8'h00
`define RSOC_P4_FORCE_MASK   8'hfc
`define RSOC_P5_FORCE_MASK   8'hc0

// Timing
`define RSOC_CLK_PERIOD_NS   10
`define RSOC_LOCO_PERIOD_NS  8000
`define RSOC_LOCO_CYCLES     \
	((`RSOC_LOCO_PERIOD_NS + `RSOC_CLK_PERIOD_NS - 1) / `RSOC_CLK_PERIOD_NS)
`define RSOC_STRETCH_TICKS   32
`define RSOC_DIV_W           16
`define RSOC_TICK_W          6

`endif

/* File: inc/rsoc_pkg.sv */
/*
 Types of the reset source and option block: sequencer states and the
 packed state record of the top module. Assumes rsoc_cfg.svh is available.
*/
`include "rsoc_cfg.svh"

package rsoc_pkg;

	// Sequencer states, one-hot
	typedef enum logic [2:0] {
		RSOC_ST_POWER = 3'b001,
		RSOC_ST_HOLD  = 3'b010,
		RSOC_ST_RUN   = 3'b100
	} rsoc_seq_type;

	// Whole state of the top module
	typedef struct packed {
		rsoc_seq_type              seq;
		logic [`RSOC_DIV_W-1:0]    div_cnt;
		logic [`RSOC_TICK_W-1:0]   tick_cnt;
		logic                      cold_warm_flag;
		logic                      pin_reset_seen;
		logic                      soft_reset_seen;
		logic                      watchdog_reset_seen;
		logic                      mode_reg_write_unlock;
		logic [7:0]                processor_mode_zero;
		logic                      monitor_reset_enable;
		logic [7:0]                start_opt;
		logic [7:0]                wdt_opt;
		logic                      pin_low;
		logic                      seq_start;
		logic                      rd_opt;
		logic [7:0]                rdata;
	} rsoc_state_type;

endpackage : rsoc_pkg

/* File: rtl/rsoc_option_store.sv */
/*
 Option byte storage: the two flash option bytes with a programmer write and
 erase port and a registered read port. Assumes a single clock and that
 sys_rst stands for the first power-up of a blank part.
*/
`timescale 1ns/1ns
`include "rsoc_cfg.svh"

module rsoc_option_store
	import rsoc_pkg::*;
(
	input  wire logic       ref_clk,       // System clock
	input  wire logic       sys_rst,       // Synchronous reset, high
	input  wire logic       prog_we,       // Programmer write strobe
	input  wire logic       prog_sel,      // 0 startup byte, 1 watchdog byte
	input  wire logic [7:0] prog_data,     // Programmer data
	input  wire logic       prog_erase,    // Block erase strobe
	input  wire logic       rd_sel,        // Read select, 1 watchdog byte
	output logic      [7:0] rd_data,       // Registered read data
	output logic      [7:0] startup_byte,  // Live startup option byte
	output logic      [7:0] watchdog_byte  // Live watchdog option byte
);

	logic [7:0] mem [0:1];
	logic [7:0] rd_q;

	// Erase wins over a write in the same cycle, as the block is wiped
	always_ff @(posedge ref_clk) begin
		if (sys_rst || prog_erase) begin
			mem[0] <= `RSOC_ERASED_BYTE;
			mem[1] <= `RSOC_ERASED_BYTE;
		end else if (prog_we) begin
			mem[prog_sel] <= prog_data;
		end
		rd_q <= sys_rst ? `RSOC_ZERO_BYTE : mem[rd_sel];
	end

	assign rd_data       = rd_q;
	assign startup_byte  = mem[0];
	assign watchdog_byte = mem[1];

endmodule : rsoc_option_store

/* File: rtl/rsoc_top.sv */
/*
 Reset source merger, reset cause flags and option byte decode of a small
 microcontroller. Assumes synchronous inputs on ref_clk, a CPU register port
 with read data one cycle after the strobe, an analog comparator level for
 the supply monitor and a one-cycle underflow pulse from the watchdog.
*/
// Behaviour
// - Five reset sources: pin, power-on, supply monitor, watchdog, software.
// - Hardware reset held as long as the reset pin stays low.
// - Writing one to the software reset bit of mode register zero resets.
// - Watchdog underflow causes a reset.
// - While the reset pin is low, all general-purpose port pins become inputs; here ports 0..3 and 6, port 4 bits 7..2 and port 5 bits 7..6 only.
// - Cause register bits one to three flag pin, software, watchdog resets.
// - Cold/warm flag clears on power-on or monitor reset, else holds.
// - Writing one sets the cold/warm flag; writing zero does nothing.
// - With monitor reset disabled, the cold/warm flag is not guaranteed.
// - Cause register bits four to six undefined, bit seven reads zero.
// - Erased option bytes read all ones, every setting inactive.
// - Option bit zero zero starts the watchdog after reset, one keeps it stopped.
// - ROM protection only when option bit two is one and bit three zero.
// - Option bits five and four select the detection threshold code.
// - The same threshold code drives power-on and monitor reset.
// - Option bit six zero enables monitor reset and power-on reset.
// - Option bit seven zero enables watchdog count-source protection.
// - Second option byte gives underflow period and refresh window selects.
// - After power-on or monitor reset ends, wait 32 slow-oscillator clocks.
// - After any reset, select the undivided slow oscillator as CPU clock.
`timescale 1ns/1ns
`include "rsoc_cfg.svh"

module rsoc_top
	import rsoc_pkg::*;
#(
	parameter int LOCO_DIV      = `RSOC_LOCO_CYCLES,   // System clocks per slow tick
	parameter int STRETCH_TICKS = `RSOC_STRETCH_TICKS  // Slow ticks after supply is good
)
(
	input  wire logic        ref_clk,               // System clock, 100 MHz
	input  wire logic        sys_rst,               // Power-on reset, sync, high
	input  wire logic        reset_pin_n,           // External reset pin, low active
	input  wire logic        vcc_below_detect,      // Supply at or below threshold
	input  wire logic        wdt_underflow,         // Watchdog underflow pulse
	input  wire logic [15:0] reg_addr,              // Register address
	input  wire logic [7:0]  reg_wdata,             // Register write data
	input  wire logic        reg_wr,                // Register write strobe
	input  wire logic        reg_rd,                // Register read strobe
	output logic      [7:0]  reg_rdata,             // Read data, cycle after strobe
	input  wire logic        opt_prog_we,           // Programmer option write
	input  wire logic        opt_prog_sel,          // 0 startup, 1 watchdog byte
	input  wire logic [7:0]  opt_prog_data,         // Programmer option data
	input  wire logic        opt_prog_erase,        // Programmer block erase
	output logic             internal_reset,        // Merged reset to the chip
	output logic             reset_sequence_start,  // Pulse at reset release
	output logic             cpu_clk_loco_select,   // Force slow undivided clock
	output logic             port_group_force_in,   // Ports 0..3 and 6 to input
	output logic      [7:0]  port4_force_in,        // Port 4 bits forced to input
	output logic      [7:0]  port5_force_in,        // Port 5 bits forced to input
	output logic             watchdog_autostart,    // Watchdog runs after reset
	output logic             rom_protect_active,    // ROM code protection on
	output logic      [1:0]  por_detect_threshold,  // Level code to power-on reset
	output logic      [1:0]  mon_detect_threshold,  // Level code to supply monitor
	output logic             monitor_reset_on,      // Monitor reset enable level
	output logic             count_source_guard,    // Count-source protection on
	output logic      [1:0]  underflow_period_sel,  // Watchdog period select
	output logic      [1:0]  refresh_window_sel     // Watchdog refresh window
);

	rsoc_state_type st;
	rsoc_state_type next_st;

	logic [7:0] opt_rd_data;
	logic [7:0] startup_byte;
	logic [7:0] watchdog_byte;

	// Two-bit field extraction, shared by three option fields
	function automatic logic [1:0] rsoc_field2(input logic [7:0] b, input int lo);
		logic [1:0] f;
		f = {b[lo + 1], b[lo]};
		return f;
	endfunction : rsoc_field2

	// Address compare, used by every write and read decode of each register
	function automatic logic rsoc_hit(input logic [15:0] a, input logic [15:0] r);
		logic h;
		h = (a == r);
		return h;
	endfunction : rsoc_hit

	// Option byte storage with registered read
	rsoc_option_store u_opt (
		.ref_clk       (ref_clk),
		.sys_rst       (sys_rst),
		.prog_we       (opt_prog_we),
		.prog_sel      (opt_prog_sel),
		.prog_data     (opt_prog_data),
		.prog_erase    (opt_prog_erase),
		.rd_sel        (rsoc_hit(reg_addr, `RSOC_ADDR_WATCHDOG_OPTION_BYTE)),
		.rd_data       (opt_rd_data),
		.startup_byte  (startup_byte),
		.watchdog_byte (watchdog_byte)
	);

	// Next state of the whole block
	always_comb begin
		logic                    tick;
		logic                    monitor_start_select_off;
		logic                    mon_trip;
		logic                    soft_req;
		logic                    in_reset;
		logic [`RSOC_DIV_W-1:0]  div_last;
		logic [`RSOC_TICK_W-1:0] tick_last;
		tick      = 1'b0;
		monitor_start_select_off = startup_byte[`RSOC_OFS_MONITOR_START_SELECT_BIT];
		mon_trip  = 1'b0;
		soft_req  = 1'b0;
		in_reset  = 1'b0;
		div_last  = `RSOC_DIV_W'(LOCO_DIV - 1);
		tick_last = `RSOC_TICK_W'(STRETCH_TICKS - 1);
		next_st   = st;
		next_st.seq_start = 1'b0;
		next_st.rd_opt    = 1'b0;
		next_st.rdata     = `RSOC_ZERO_BYTE;
		next_st.pin_low   = ~reset_pin_n;

		// Slow oscillator stand-in: one-cycle enable from a divider
		if (st.div_cnt == div_last) begin
			next_st.div_cnt = '0;
			tick = 1'b1;
		end else begin
			next_st.div_cnt = st.div_cnt + `RSOC_DIV_W'(1);
		end

		// Monitor trips only while its run-time enable is set
		mon_trip = st.monitor_reset_enable & vcc_below_detect;

		// Software request needs the unlock bit, else the write is lost
		soft_req = reg_wr && rsoc_hit(reg_addr, `RSOC_ADDR_PM0)
			&& st.mode_reg_write_unlock
			&& reg_wdata[`RSOC_PM0_SOFT_BIT];

		unique case (st.seq)
			RSOC_ST_POWER: begin
				in_reset = 1'b1;
				next_st.cold_warm_flag = 1'b0;
				if (!reset_pin_n) begin
					next_st.tick_cnt = '0;
				end else if (monitor_start_select_off) begin
					// Power-on reset only works with the monitor enabled
					next_st.seq = RSOC_ST_RUN;
					next_st.seq_start = 1'b1;
				end else if (vcc_below_detect) begin
					next_st.tick_cnt = '0;
				end else if (tick) begin
					if (st.tick_cnt == tick_last) begin
						next_st.seq = RSOC_ST_RUN;
						next_st.seq_start = 1'b1;
						next_st.tick_cnt = '0;
					end else begin
						next_st.tick_cnt = st.tick_cnt + `RSOC_TICK_W'(1);
					end
				end
			end
			RSOC_ST_HOLD: begin
				in_reset = 1'b1;
				if (!monitor_start_select_off && vcc_below_detect) begin
					// Supply loss inside a warm reset escalates
					next_st.seq = RSOC_ST_POWER;
					next_st.tick_cnt = '0;
				end else if (!reset_pin_n) begin
					next_st.pin_reset_seen      = 1'b1;
					next_st.soft_reset_seen     = 1'b0;
					next_st.watchdog_reset_seen = 1'b0;
				end else begin
					next_st.seq = RSOC_ST_RUN;
					next_st.seq_start = 1'b1;
				end
			end
			RSOC_ST_RUN: begin
				// Priority: supply, pin, watchdog, software
				if (mon_trip) begin
					next_st.seq = RSOC_ST_POWER;
					next_st.tick_cnt = '0;
					next_st.cold_warm_flag = 1'b0;
					next_st.pin_reset_seen      = 1'b0;
					next_st.soft_reset_seen     = 1'b0;
					next_st.watchdog_reset_seen = 1'b0;
				end else if (!reset_pin_n) begin
					next_st.seq = RSOC_ST_HOLD;
					next_st.pin_reset_seen      = 1'b1;
					next_st.soft_reset_seen     = 1'b0;
					next_st.watchdog_reset_seen = 1'b0;
				end else if (wdt_underflow) begin
					next_st.seq = RSOC_ST_HOLD;
					next_st.pin_reset_seen      = 1'b0;
					next_st.soft_reset_seen     = 1'b0;
					next_st.watchdog_reset_seen = 1'b1;
				end else if (soft_req) begin
					next_st.seq = RSOC_ST_HOLD;
					next_st.pin_reset_seen      = 1'b0;
					next_st.soft_reset_seen     = 1'b1;
					next_st.watchdog_reset_seen = 1'b0;
				end else if (reg_wr) begin
					// Register writes, only while the CPU runs
					if (rsoc_hit(reg_addr, `RSOC_ADDR_WRITE_PROTECT_REGISTER)) begin
						next_st.mode_reg_write_unlock =
							reg_wdata[`RSOC_WRITE_PROTECT_REGISTER_UNLOCK_BIT];
					end
					if (rsoc_hit(reg_addr, `RSOC_ADDR_PM0)
						&& st.mode_reg_write_unlock) begin
						next_st.processor_mode_zero = reg_wdata;
						next_st.processor_mode_zero[`RSOC_PM0_SOFT_BIT] = 1'b0;
					end
					if (rsoc_hit(reg_addr, `RSOC_ADDR_MONITOR_CONTROL_REGISTER)) begin
						next_st.monitor_reset_enable =
							reg_wdata[`RSOC_MONITOR_CONTROL_REGISTER_EN_BIT];
					end
					// Only a one has effect; bit seven is not stored
					if (rsoc_hit(reg_addr, `RSOC_ADDR_RESET_CAUSE_FLAGS)
						&& reg_wdata[`RSOC_RF_CWR_BIT]) begin
						next_st.cold_warm_flag = 1'b1;
					end
				end
			end
			default: begin
				// Illegal code: restart as if power came up
				next_st.seq = RSOC_ST_POWER;
				next_st.tick_cnt = '0;
			end
		endcase

		// While held in reset, registers take their reset values
		if (in_reset) begin
			next_st.mode_reg_write_unlock = 1'b0;
			next_st.processor_mode_zero   = `RSOC_PM0_RESET;
			// Monitor run-time enable follows the option bit after reset
			next_st.monitor_reset_enable  = ~monitor_start_select_off;
			// Option settings are sampled throughout reset, used after it
			next_st.start_opt = startup_byte;
			next_st.wdt_opt   = watchdog_byte;
		end

		// Register reads; option bytes come from the store's own register
		if (reg_rd) begin
			if (rsoc_hit(reg_addr, `RSOC_ADDR_RESET_CAUSE_FLAGS)) begin
				// Bits four to six undefined, shown as zero; bit seven zero
				next_st.rdata[`RSOC_RF_CWR_BIT] = st.cold_warm_flag;
				next_st.rdata[`RSOC_RF_HWR_BIT] = st.pin_reset_seen;
				next_st.rdata[`RSOC_RF_SWR_BIT] = st.soft_reset_seen;
				next_st.rdata[`RSOC_RF_WDR_BIT] = st.watchdog_reset_seen;
			end else if (rsoc_hit(reg_addr, `RSOC_ADDR_PM0)) begin
				next_st.rdata = st.processor_mode_zero;
			end else if (rsoc_hit(reg_addr, `RSOC_ADDR_WRITE_PROTECT_REGISTER)) begin
				next_st.rdata[`RSOC_WRITE_PROTECT_REGISTER_UNLOCK_BIT] = st.mode_reg_write_unlock;
			end else if (rsoc_hit(reg_addr, `RSOC_ADDR_MONITOR_CONTROL_REGISTER)) begin
				next_st.rdata[`RSOC_MONITOR_CONTROL_REGISTER_EN_BIT] = st.monitor_reset_enable;
			end else if (rsoc_hit(reg_addr, `RSOC_ADDR_OFS)
				|| rsoc_hit(reg_addr, `RSOC_ADDR_WATCHDOG_OPTION_BYTE)) begin
				next_st.rd_opt = 1'b1;
			end
		end
	end

	// State register; power-on is the only reset of the block's own flops
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st.seq                   <= RSOC_ST_POWER;
			st.div_cnt               <= '0;
			st.tick_cnt              <= '0;
			st.cold_warm_flag        <= 1'b0;
			st.pin_reset_seen        <= 1'b0;
			st.soft_reset_seen       <= 1'b0;
			st.watchdog_reset_seen   <= 1'b0;
			st.mode_reg_write_unlock <= 1'b0;
			st.processor_mode_zero   <= `RSOC_PM0_RESET;
			st.monitor_reset_enable  <= 1'b0;
			st.start_opt             <= `RSOC_ERASED_BYTE;
			st.wdt_opt               <= `RSOC_ERASED_BYTE;
			st.pin_low               <= 1'b0;
			st.seq_start             <= 1'b0;
			st.rd_opt                <= 1'b0;
			st.rdata                 <= `RSOC_ZERO_BYTE;
		end else begin
			st <= next_st;
		end
	end

	// Read data: zero outside the cycle after a read strobe
	assign reg_rdata = st.rd_opt ? opt_rd_data : st.rdata;

	// Merged reset is a state decode, so it leaves in step with the clock
	assign internal_reset       = (st.seq != RSOC_ST_RUN);
	assign reset_sequence_start = st.seq_start;
	assign cpu_clk_loco_select  = internal_reset;

	// Port direction override while the pin is held low
	assign port_group_force_in = st.pin_low;
	assign port4_force_in      = st.pin_low ? `RSOC_P4_FORCE_MASK : `RSOC_ZERO_BYTE;
	assign port5_force_in      = st.pin_low ? `RSOC_P5_FORCE_MASK : `RSOC_ZERO_BYTE;

	// Startup option decode; erased byte leaves every feature inactive
	assign watchdog_autostart = ~st.start_opt[`RSOC_OFS_WATCHDOG_AUTOSTART_SELECT_BIT];
	assign rom_protect_active = st.start_opt[`RSOC_OFS_ROM_PROTECT_GATE_BIT]
		& ~st.start_opt[`RSOC_OFS_ROMCP_BIT];
	// One threshold code feeds both detectors, never two different levels
	assign por_detect_threshold = rsoc_field2(st.start_opt, `RSOC_OFS_VDSEL_LO);
	assign mon_detect_threshold = rsoc_field2(st.start_opt, `RSOC_OFS_VDSEL_LO);
	assign monitor_reset_on     = st.monitor_reset_enable;
	assign count_source_guard   = ~st.start_opt[`RSOC_OFS_CSPRO_BIT];

	// Watchdog option decode
	assign underflow_period_sel = rsoc_field2(st.wdt_opt, `RSOC_WATCHDOG_OPTION_BYTE_UFS_LO);
	assign refresh_window_sel   = rsoc_field2(st.wdt_opt, `RSOC_WATCHDOG_OPTION_BYTE_RCS_LO);

endmodule : rsoc_top

/* File: test/rsoc_top_props.sv */
/*
 Assertions on the ports of the reset source and option block.
 Assumes a bind from the testbench top and the single clock ref_clk.
*/
`timescale 1ns/1ns

module rsoc_top_props (
	input wire logic        ref_clk,               // System clock
	input wire logic        sys_rst,               // Synchronous reset
	input wire logic        reset_pin_n,           // Reset pin level
	input wire logic        vcc_below_detect,      // Supply low flag
	input wire logic        wdt_underflow,         // Watchdog pulse
	input wire logic [15:0] reg_addr,              // Register address
	input wire logic [7:0]  reg_wdata,             // Write data
	input wire logic        reg_wr,                // Write strobe
	input wire logic        reg_rd,                // Read strobe
	input wire logic [7:0]  reg_rdata,             // Read data
	input wire logic        internal_reset,        // Merged reset
	input wire logic        reset_sequence_start,  // Release pulse
	input wire logic        cpu_clk_loco_select,   // Slow clock select
	input wire logic        port_group_force_in,   // Port group to input
	input wire logic [7:0]  port4_force_in,        // Port 4 force mask
	input wire logic [7:0]  port5_force_in,        // Port 5 force mask
	input wire logic        watchdog_autostart,    // Watchdog autostart
	input wire logic        rom_protect_active,    // ROM protection
	input wire logic [1:0]  por_detect_threshold,  // Power-on level code
	input wire logic [1:0]  mon_detect_threshold   // Monitor level code
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	// Unlock write followed at once by the soft request
	sequence s_unlock;
		reg_wr && reg_addr == 16'h000a && reg_wdata[1] && !internal_reset;
	endsequence
	sequence s_soft;
		reg_wr && reg_addr == 16'h0004 && reg_wdata[3];
	endsequence

	soft_reset_a: assert property (s_unlock ##1 s_soft |=> internal_reset)
		else $error("soft request did not reset");
	pin_hold_a: assert property (!reset_pin_n |=> internal_reset)
		else $error("pin low without reset");
	pin_ports_a: assert property (!reset_pin_n |=> port_group_force_in &&
		port4_force_in == 8'hfc && port5_force_in == 8'hc0)
		else $error("ports not forced to input");
	ports_idle_a: assert property (reset_pin_n [*2] |-> !port_group_force_in &&
		port4_force_in == 8'h00 && port5_force_in == 8'h00)
		else $error("ports forced with pin high");
	wdt_reset_a: assert property (!internal_reset && reset_pin_n &&
		!vcc_below_detect && wdt_underflow |=> internal_reset)
		else $error("underflow did not reset");
	clk_select_a: assert property (cpu_clk_loco_select == internal_reset)
		else $error("slow clock select differs from reset");
	thr_same_a: assert property (por_detect_threshold == mon_detect_threshold)
		else $error("threshold codes differ");
	release_start_a: assert property (reset_sequence_start == $fell(internal_reset))
		else $error("start pulse not at release");
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data without read");
	flags_upper_a: assert property (reg_rd && reg_addr == 16'h000b |=>
		reg_rdata[7:4] == 4'h0)
		else $error("upper flag bits not zero");
	opts_frozen_a: assert property (!internal_reset [*2] |-> $stable(watchdog_autostart)
		&& $stable(rom_protect_active))
		else $error("option decode changed while running");
endmodule : rsoc_top_props

/* File: test/rsoc_ext_model.sv */
/*
 Model of the reset pin circuit, supply detector and watchdog counter.
 Assumes the caller invokes its tasks from the testbench between edges.
*/
`timescale 1ns/1ns

module rsoc_ext_model (
	input  wire logic ref_clk,          // System clock
	output logic      reset_pin_n,      // Reset pin level
	output logic      vcc_below_detect, // Supply at or below level
	output logic      wdt_underflow     // Watchdog underflow pulse
);
	// Pin pulled up, supply good, watchdog quiet
	initial begin
		reset_pin_n = 1'b1;
		vcc_below_detect = 1'b0;
		wdt_underflow = 1'b0;
	end

	// Pin held low for n cycles, then released to its pull-up
	task automatic pin_pulse(input int n);
		@(posedge ref_clk);
		reset_pin_n <= 1'b0;
		repeat (n) @(posedge ref_clk);
		reset_pin_n <= 1'b1;
	endtask : pin_pulse

	// Supply dips below the level, then recovers
	task automatic supply_dip(input int n);
		@(posedge ref_clk);
		vcc_below_detect <= 1'b1;
		repeat (n) @(posedge ref_clk);
		vcc_below_detect <= 1'b0;
	endtask : supply_dip

	// Single-cycle underflow, as the counter gives it
	task automatic wdt_pulse();
		@(posedge ref_clk);
		wdt_underflow <= 1'b1;
		@(posedge ref_clk);
		wdt_underflow <= 1'b0;
	endtask : wdt_pulse
endmodule : rsoc_ext_model

/* File: test/tb.sv */
/*
 Self-checking bench of the reset source and option block.
 Assumes the external model drives the pin, supply and watchdog inputs.
*/
`timescale 1ns/1ns

module tb;
	localparam int LDIV  = 4;
	localparam int TICKS = 32;
	logic        ref_clk = 1'b0, sys_rst = 1'b1;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0]  reg_wdata = 8'h00, opt_prog_data = 8'h00, q, reg_rdata;
	logic        reg_wr = 1'b0, reg_rd = 1'b0, opt_prog_we = 1'b0, opt_prog_sel = 1'b0;
	logic        opt_prog_erase = 1'b0, reset_pin_n, vcc_below_detect, wdt_underflow;
	logic        internal_reset, reset_sequence_start, cpu_clk_loco_select;
	logic        port_group_force_in, watchdog_autostart, rom_protect_active;
	logic        monitor_reset_on, count_source_guard;
	logic [7:0]  port4_force_in, port5_force_in, s, w;
	logic [1:0]  por_detect_threshold, mon_detect_threshold;
	logic [1:0]  underflow_period_sel, refresh_window_sel;
	int          n_errors = 0, n_checks = 0, c;

	rsoc_top #(.LOCO_DIV(LDIV), .STRETCH_TICKS(TICKS)) u_dut (.ref_clk, .sys_rst,
		.reset_pin_n, .vcc_below_detect, .wdt_underflow, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .opt_prog_we, .opt_prog_sel, .opt_prog_data,
		.opt_prog_erase, .internal_reset, .reset_sequence_start, .cpu_clk_loco_select,
		.port_group_force_in, .port4_force_in, .port5_force_in, .watchdog_autostart,
		.rom_protect_active, .por_detect_threshold, .mon_detect_threshold,
		.monitor_reset_on, .count_source_guard, .underflow_period_sel, .refresh_window_sel);
	rsoc_ext_model u_ext (.ref_clk, .reset_pin_n, .vcc_below_detect, .wdt_underflow);

	// 100 MHz clock
	always #5 ref_clk = ~ref_clk;

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_rng(input int got, input int lo, input int hi);
		n_checks++;
		if (got < lo || got > hi) begin
			n_errors++;
			$display("[ERR] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask : chk_rng

	// One bus cycle; strobes change only right after an edge
	task automatic bus(input logic wr, input logic rd, input logic [15:0] a,
		input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= wr;
		reg_rd <= rd;
		reg_addr <= a;
		reg_wdata <= d;
	endtask : bus

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
		bus(1'b0, 1'b0, a, d);
	endtask : wr

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [15:0] a, output logic [7:0] r);
		bus(1'b0, 1'b1, a, 8'h00);
		bus(1'b0, 1'b0, a, 8'h00);
		#1 r = reg_rdata;
	endtask : rd

	task automatic prog(input logic sel, input logic [7:0] d, input logic er);
		@(posedge ref_clk);
		opt_prog_we <= ~er;
		opt_prog_sel <= sel;
		opt_prog_data <= d;
		opt_prog_erase <= er;
		@(posedge ref_clk);
		opt_prog_we <= 1'b0;
		opt_prog_erase <= 1'b0;
	endtask : prog

	// Bounded wait for reset to rise, then for its release
	task automatic wait_run(output int n);
		n = 0;
		while (internal_reset !== 1'b1 && n < 8) begin
			@(posedge ref_clk);
			#1 n++;
		end
		n = 0;
		while (internal_reset !== 1'b0 && n < 2000) begin
			@(posedge ref_clk);
			#1 n++;
		end
		chk({7'h00, internal_reset}, 8'h00);
	endtask : wait_run

	task automatic check_opts(input logic [7:0] so, input logic [7:0] wo);
		chk({2'b00, watchdog_autostart, rom_protect_active, mon_detect_threshold,
			count_source_guard, monitor_reset_on},
			{2'b00, ~so[0], so[2] & ~so[3], so[5:4], ~so[7], ~so[6]});
		chk({4'h0, underflow_period_sel, refresh_window_sel}, {4'h0, wo[1:0], wo[3:2]});
	endtask : check_opts

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test

	// Watchdog on the whole run, far beyond the expected few hundred cycles
	initial begin
		#200000;
		n_errors++;
		$display("[ERR] %0t run did not complete", $time);
		finish_test();
	end

	initial begin
		repeat (16) @(posedge ref_clk);
		sys_rst <= 1'b0;
		wait_run(c);
		check_opts(8'hff, 8'hff);
		rd(16'h0100, q);
		chk(q, 8'h00);
		rd(16'h000b, q);
		chk(q & 8'hfe, 8'h00);
		wr(16'h000b, 8'h01);
		rd(16'h000b, q);
		chk(q, 8'h01);
		wr(16'h000b, 8'h00);
		rd(16'h000b, q);
		chk(q, 8'h01);
		$display("flags and options after power-up done");
		wr(16'h0004, 8'h08);
		repeat (3) @(posedge ref_clk);
		#1 chk({7'h00, internal_reset}, 8'h00);
		bus(1'b1, 1'b0, 16'h000a, 8'h02);
		bus(1'b1, 1'b0, 16'h0004, 8'h08);
		bus(1'b0, 1'b0, 16'h0000, 8'h00);
		wait_run(c);
		rd(16'h000b, q);
		chk(q, 8'h05);
		$display("soft reset done");
		fork
			u_ext.pin_pulse(5);
			begin
				repeat (3) @(posedge ref_clk);
				#1 chk({internal_reset, port_group_force_in, 6'h00}, 8'hc0);
				chk(port4_force_in, 8'hfc);
				chk(port5_force_in, 8'hc0);
			end
		join
		wait_run(c);
		rd(16'h000b, q);
		chk(q, 8'h03);
		u_ext.wdt_pulse();
		wait_run(c);
		rd(16'h000b, q);
		chk(q, 8'h09);
		$display("pin and watchdog resets done");
		for (int k = 0; k < 4; k++) begin
			s = {k[1], 1'b1, k[1:0], k[1:0], 1'b1, k[0]};
			w = {4'hf, k[1:0], k[1:0]};
			prog(1'b0, s, 1'b0);
			prog(1'b1, w, 1'b0);
			u_ext.pin_pulse(3);
			wait_run(c);
			check_opts(s, w);
		end
		$display("option decode done");
		prog(1'b0, 8'hbf, 1'b0);
		u_ext.pin_pulse(3);
		wait_run(c);
		check_opts(8'hbf, 8'hff);
		wr(16'h000b, 8'h01);
		u_ext.supply_dip(3);
		wait_run(c);
		chk_rng(c, TICKS * LDIV - 2, TICKS * LDIV + LDIV + 4);
		rd(16'h000b, q);
		chk(q, 8'h00);
		$display("supply monitor reset done");
		prog(1'b0, 8'h00, 1'b1);
		u_ext.pin_pulse(3);
		wait_run(c);
		check_opts(8'hff, 8'hff);
		$display("erase done");
		finish_test();
	end
endmodule : tb

bind rsoc_top rsoc_top_props u_props (.ref_clk, .sys_rst, .reset_pin_n, .vcc_below_detect,
	.wdt_underflow, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .internal_reset,
	.reset_sequence_start, .cpu_clk_loco_select, .port_group_force_in, .port4_force_in,
	.port5_force_in, .watchdog_autostart, .rom_protect_active, .por_detect_threshold,
	.mon_detect_threshold);
